//--- pkg/sdt_pkg.sv
// Shared constants, command codes and state type of the SDRAM timing controller
package sdt_pkg;

  // Clock and conversion from nanoseconds to whole cycles
  localparam int CLK_PERIOD_PS = 5000;

  function automatic int ns_up(input int ns);
    return (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction

  // Device timing in its own units, both speed grades
  localparam int RC_FAST_NS = 60;
  localparam int RC_SLOW_NS = 63;
  localparam int RAS_MIN_NS = 42;
  localparam int RAS_MAX_NS = 100000;
  localparam int RP_FAST_NS = 18;
  localparam int RP_SLOW_NS = 20;
  localparam int RCD_FAST_NS = 18;
  localparam int RCD_SLOW_NS = 20;
  localparam int RRD_FAST_NS = 12;
  localparam int RRD_SLOW_NS = 14;
  localparam int WR_CLK = 2;
  localparam int CKA_CLK = 1;
  localparam int CKA_EXTRA_NS = 3;
  localparam int MRD_CLK = 2;
  localparam int REF_WINDOW_MS = 64;
  localparam int REF_COUNT = 4096;
  localparam int INIT_WAIT_US = 200;
  localparam int INIT_REFRESHES = 2;

  // Derived cycle counts
  localparam int RC_FAST_CYC = ns_up(RC_FAST_NS);
  localparam int RC_SLOW_CYC = ns_up(RC_SLOW_NS);
  localparam int RAS_MIN_CYC = ns_up(RAS_MIN_NS);
  localparam int RAS_MAX_CYC = RAS_MAX_NS * 1000 / CLK_PERIOD_PS;
  localparam int RP_FAST_CYC = ns_up(RP_FAST_NS);
  localparam int RP_SLOW_CYC = ns_up(RP_SLOW_NS);
  localparam int RCD_FAST_CYC = ns_up(RCD_FAST_NS);
  localparam int RCD_SLOW_CYC = ns_up(RCD_SLOW_NS);
  localparam int RRD_FAST_CYC = ns_up(RRD_FAST_NS);
  localparam int RRD_SLOW_CYC = ns_up(RRD_SLOW_NS);
  localparam int CKA_CYC = CKA_CLK + ns_up(CKA_EXTRA_NS);
  localparam int REFI_NS = REF_WINDOW_MS * 1000000 / REF_COUNT;
  localparam int REFI_CYC = REFI_NS * 1000 / CLK_PERIOD_PS;
  localparam int INIT_WAIT_CYC = ns_up(INIT_WAIT_US * 1000);

  // Timer bank layout
  localparam int TW = 16;
  localparam int NT = 7;
  localparam int T_RC = 0;
  localparam int T_RAS = 1;
  localparam int T_RP = 2;
  localparam int T_RCD = 3;
  localparam int T_RRD = 4;
  localparam int T_WAIT = 5;
  localparam int T_REFI = 6;

  function automatic logic [TW-1:0] cyc(input int c);
    return TW'(c - 1);
  endfunction

  // Commands as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;

  // Mode word: burst length 1, sequential, CAS latency 3
  localparam logic [11:0] MODE_WORD = 12'h030;
  localparam int CAS_LAT = 3;
  localparam int AP_BIT = 10;

  typedef enum logic [2:0] {
    S_RESET, S_INIT_WAIT, S_INIT_REF, S_INIT_MRS, S_IDLE, S_RCD, S_PRE, S_PDN
  } sdt_state_t;

endpackage

//--- pkg/sdt_tmr_if.sv
// Timer bank connection between the controller and its countdown timers
`timescale 1ns/10ps
`default_nettype none
interface sdt_tmr_if import sdt_pkg::*; ();
  logic [NT-1:0] load;
  logic [NT-1:0][TW-1:0] val;
  logic [NT-1:0] done;
  modport ctrl (output load, output val, input done);
  modport tmr (input load, input val, output done);
endinterface
`default_nettype wire

//--- sim/sdt_ctrl_tb.sv
// Self-checking bench for the SDRAM timing controller
`timescale 1ns/10ps
`default_nettype none
module sdt_ctrl_tb import sdt_pkg::*; ;
  logic SYS_CLK = 1'h0;
  logic RESET_N = 1'h0;
  logic GRADE_SLOW = 1'h0;
  logic REQ = 1'h0;
  logic REQ_WR = 1'h0;
  logic REQ_AP = 1'h0;
  logic PWR_DOWN = 1'h0;
  logic [21:0] REQ_ADDR = 22'h0;
  logic [15:0] REQ_WDATA = 16'h0;
  logic ACK, RD_VALID, READY, SDR_CKE, SDR_DQ_OE_N;
  logic SDR_CS_N, SDR_RAS_N, SDR_CAS_N, SDR_WE_N;
  logic [15:0] RD_DATA, SDR_DQ_O, SDR_DQ_I;
  logic [1:0] SDR_BA, SDR_DQM;
  logic [11:0] SDR_A;
  logic [3:0] cmd;
  int failures = 0;
  int tests_run = 0;
  int ref_cnt = 0;
  int model_errs;
  assign cmd = {SDR_CS_N, SDR_RAS_N, SDR_CAS_N, SDR_WE_N};
  initial
    forever #2.5 SYS_CLK = ~SYS_CLK;
  sdt_ctrl #(.INIT_WAIT_CYC_P(20), .RAS_MAX_CYC_P(100)) dut (.SYS_CLK(SYS_CLK),
    .RESET_N(RESET_N), .GRADE_SLOW(GRADE_SLOW), .REQ(REQ), .REQ_WR(REQ_WR),
    .REQ_AP(REQ_AP), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .PWR_DOWN(PWR_DOWN),
    .ACK(ACK), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .READY(READY), .SDR_CKE(SDR_CKE),
    .SDR_CS_N(SDR_CS_N), .SDR_RAS_N(SDR_RAS_N), .SDR_CAS_N(SDR_CAS_N),
    .SDR_WE_N(SDR_WE_N), .SDR_BA(SDR_BA), .SDR_A(SDR_A), .SDR_DQM(SDR_DQM),
    .SDR_DQ_O(SDR_DQ_O), .SDR_DQ_OE_N(SDR_DQ_OE_N), .SDR_DQ_I(SDR_DQ_I));
  sdt_mem_model #(.INIT_P(20), .RASMAX_P(100)) u_mem (.clk(SYS_CLK), .rst_n(RESET_N),
    .slow(GRADE_SLOW), .cke(SDR_CKE), .cmd(cmd), .ba(SDR_BA), .a(SDR_A),
    .dq_o(SDR_DQ_O), .dq_oe_n(SDR_DQ_OE_N), .dq_i(SDR_DQ_I), .errs(model_errs));
  always @(negedge SYS_CLK)
    if (SDR_CKE && cmd === CMD_REF)
      ref_cnt++;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t %s: got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string m);
    chk16({15'h0, got}, {15'h0, exp}, m);
  endtask
  task automatic hang(input string m);
    failures++;
    $display("BAD %0t no %s", $time, m);
    end_of_test();
  endtask
  task automatic access(input logic wr, input logic ap, input logic [21:0] addr,
                        input logic [15:0] wd, output logic [15:0] rd);
    int k;
    rd = 16'hxxxx;
    REQ = 1'h1;
    REQ_WR = wr;
    REQ_AP = ap;
    REQ_ADDR = addr;
    REQ_WDATA = wd;
    k = 0;
    do
    begin
      @(negedge SYS_CLK);
      k++;
    end
    while (ACK !== 1'h1 && k < 400);
    if (k >= 400)
      hang("acknowledge");
    REQ = 1'h0;
    chk16({12'h0, cmd}, {12'h0, wr ? CMD_WR : CMD_RD}, "column command");
    chk16(16'({SDR_BA, SDR_A}), 16'({addr[21:20], 2'(wr & ap), 2'h0, addr[7:0]}), "col");
    if (wr)
    begin
      chk16(SDR_DQ_O, wd, "write data");
      chk1(SDR_DQ_OE_N, 1'h0, "data drive");
    end
    else
    begin
      chk1(SDR_DQ_OE_N, 1'h1, "no drive on read");
      k = 0;
      while (RD_VALID !== 1'h1 && k < 8)
      begin
        @(negedge SYS_CLK);
        k++;
      end
      if (k >= 8)
        hang("read data");
      rd = RD_DATA;
    end
    @(negedge SYS_CLK);
  endtask
  task automatic wr_rd(input logic [21:0] addr, input logic [15:0] d, input logic ap);
    logic [15:0] rd;
    access(1'h1, ap, addr, d, rd);
    access(1'h0, 1'h0, addr, 16'h0, rd);
    chk16(rd, d, "read back");
  endtask
  task automatic wait_cke(input logic v);
    int k;
    k = 0;
    while (SDR_CKE !== v && k < 60)
    begin
      @(negedge SYS_CLK);
      k++;
    end
    chk1(SDR_CKE, v, "clock enable");
  endtask
  task automatic t_init();
    int k;
    @(negedge SYS_CLK);
    chk16({11'h0, SDR_DQM, SDR_CKE, cmd}, {11'h0, 2'h3, 1'h1, CMD_NOP}, "reset pins");
    repeat (15) @(negedge SYS_CLK);
    RESET_N = 1'h1;
    k = 0;
    while (READY !== 1'h1 && k < 300)
    begin
      @(negedge SYS_CLK);
      k++;
    end
    if (k >= 300)
      hang("ready");
    chk1(k >= 20, 1'h1, "power-up wait");
    chk16({14'h0, SDR_DQM}, 16'h0, "mask after init");
  endtask
  task automatic t_banks();
    logic [15:0] rd;
    for (int b = 0; b < 4; b++)
      access(1'h1, 1'h1, {2'(b), 12'h0a0, 8'h40}, 16'hc0d0 ^ 16'(b), rd);
    for (int b = 0; b < 4; b++)
    begin
      access(1'h0, 1'h0, {2'(b), 12'h0a0, 8'h40}, 16'h0, rd);
      chk16(rd, 16'hc0d0 ^ 16'(b), "bank data");
    end
  endtask
  task automatic t_pdown();
    logic [15:0] rd;
    PWR_DOWN = 1'h1;
    wait_cke(1'h0);
    repeat (10) @(negedge SYS_CLK);
    PWR_DOWN = 1'h0;
    wait_cke(1'h1);
    access(1'h0, 1'h0, 22'h000503, 16'h0, rd);
    chk16(rd, 16'h1234, "read after wake");
  endtask
  task automatic t_refresh();
    int r0;
    r0 = ref_cnt;
    repeat (2 * REFI_CYC + 200) @(negedge SYS_CLK);
    chk1(ref_cnt - r0 >= 2, 1'h1, "periodic refresh");
  endtask
  initial
  begin
    t_init();
    wr_rd(22'h000503, 16'h1234, 1'h0);
    wr_rd(22'h000703, 16'h8e71, 1'h1);
    t_banks();
    t_pdown();
    t_refresh();
    GRADE_SLOW = 1'h1;
    t_banks();
    wr_rd(22'h3fff00, 16'hffff, 1'h0);
    repeat (20) @(negedge SYS_CLK);
    chk16(16'(model_errs), 16'h0, "device spacing faults");
    end_of_test();
  end
endmodule
`default_nettype wire

//--- sim/sdt_mem_model.sv
// Behavioural SDRAM that checks command spacing and answers reads
`timescale 1ns/10ps
`default_nettype none
module sdt_mem_model import sdt_pkg::*; #(
  parameter int INIT_P = 20,
  parameter int RASMAX_P = 100
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic cke,
  input wire logic [3:0] cmd,
  input wire logic [1:0] ba,
  input wire logic [11:0] a,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe_n,
  output logic [15:0] dq_i,
  output int errs
);
  longint n, t_ref, t_mrs, t_cke, t_any;
  longint t_act[4], t_pre[4], t_wr[4], t_ap[4];
  logic [3:0] open_b;
  logic [11:0] row[4];
  logic [15:0] mem[int];
  logic [15:0] rd_w[3];
  logic [2:0] rd_p;
  logic [15:0] noise;
  logic mode_ok, cke_q;
  int refs, k;
  int rc, rp, rcd, rrd;
  // Grade limits in whole cycles
  assign rc = slow ? RC_SLOW_CYC : RC_FAST_CYC;
  assign rp = slow ? RP_SLOW_CYC : RP_FAST_CYC;
  assign rcd = slow ? RCD_SLOW_CYC : RCD_FAST_CYC;
  assign rrd = slow ? RRD_SLOW_CYC : RRD_FAST_CYC;
  // Read word only in its sample cycle, a moving pattern otherwise
  assign dq_i = rd_p[2] ? rd_w[2] : noise;
  initial errs = 0;
  task automatic bad(input string m);
    errs++;
    $display("BAD %0t model: %s", $time, m);
  endtask
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      n = 0;
      t_ref = -999;
      t_mrs = -999;
      t_cke = -999;
      t_any = -999;
      for (int b = 0; b < 4; b++)
      begin
        t_act[b] = 0;
        t_pre[b] = -999;
        t_wr[b] = -999;
        t_ap[b] = -999;
      end
      open_b = 4'hf;
      mode_ok = 1'h0;
      cke_q = 1'h1;
      refs = 0;
      rd_p <= 3'h0;
      noise <= 16'h5a5a;
    end
    else
    begin
      n++;
      k = int'({ba, row[ba], a[7:0]});
      noise <= noise + 16'h3b1d;
      rd_p <= {rd_p[1:0], cke && cmd == CMD_RD};
      rd_w[0] <= mem.exists(k) ? mem[k] : noise;
      rd_w[1] <= rd_w[0];
      rd_w[2] <= rd_w[1];
      if (cke && !cke_q)
        t_cke = n;
      cke_q = cke;
      for (int b = 0; b < 4; b++)
        if (open_b[b] && n - t_act[b] > RASMAX_P)
          bad("row open too long");
      if (cmd != CMD_NOP && !cke)
        bad("command in power-down");
      if (cmd != CMD_NOP && cke && (n - t_cke < CKA_CYC || n < INIT_P))
        bad("command too early");
      if (cmd inside {CMD_ACT, CMD_REF} && n - t_mrs < MRD_CLK)
        bad("too soon after mode load");
      if (cke)
        case (cmd)
          CMD_ACT:
          begin
            if (!mode_ok || open_b[ba] || n - t_pre[ba] < rp)
              bad("activate early");
            if (n - t_act[ba] < rc || n - t_any < rrd)
              bad("activate spacing");
            if (n - t_ap[ba] < WR_CLK + rp)
              bad("activate after auto-precharge");
            open_b[ba] = 1'h1;
            row[ba] = a;
            t_act[ba] = n;
            t_any = n;
          end
          CMD_REF:
          begin
            if (open_b != 4'h0 || n - t_ref < rc)
              bad("refresh spacing");
            if (mode_ok && n - t_ref > REFI_CYC + 40)
              bad("refresh late");
            for (int b = 0; b < 4; b++)
              if (n - t_ap[b] < WR_CLK + rp)
                bad("refresh after auto-precharge");
            t_ref = n;
            refs++;
          end
          CMD_PRE:
            for (int b = 0; b < 4; b++)
              if (a[10] || ba == 2'(b))
              begin
                if (open_b[b] && (n - t_act[b] < RAS_MIN_CYC || n - t_wr[b] < WR_CLK))
                  bad("early precharge");
                open_b[b] = 1'h0;
                t_pre[b] = n;
              end
          CMD_RD, CMD_WR:
          begin
            if (!open_b[ba] || n - t_act[ba] < rcd)
              bad("column command early");
            if (cmd == CMD_WR)
            begin
              if (dq_oe_n)
                bad("write without data");
              mem[k] = dq_o;
              t_wr[ba] = n;
            end
            if (cmd == CMD_WR && a[10])
            begin
              if (n - t_act[ba] < RAS_MIN_CYC)
                bad("auto-precharge early");
              open_b[ba] = 1'h0;
              t_ap[ba] = n;
            end
          end
          CMD_MRS:
          begin
            if (open_b != 4'h0 || refs < INIT_REFRESHES || a != MODE_WORD)
              bad("mode load out of order");
            mode_ok = 1'h1;
            t_mrs = n;
          end
          default: ;
        endcase
    end
endmodule
`default_nettype wire

//--- verilog/sdt_ctrl.sv
// SDRAM command and timing controller driving a four-bank synchronous DRAM
`timescale 1ns/10ps
`default_nettype none
module sdt_ctrl import sdt_pkg::*; #(
  parameter int INIT_WAIT_CYC_P = INIT_WAIT_CYC,
  parameter int RAS_MAX_CYC_P = RAS_MAX_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic GRADE_SLOW,
  input wire logic REQ,
  input wire logic REQ_WR,
  input wire logic REQ_AP,
  input wire logic [21:0] REQ_ADDR,
  input wire logic [15:0] REQ_WDATA,
  input wire logic PWR_DOWN,
  output logic ACK,
  output logic [15:0] RD_DATA,
  output logic RD_VALID,
  output logic READY,
  output logic SDR_CKE,
  output logic SDR_CS_N,
  output logic SDR_RAS_N,
  output logic SDR_CAS_N,
  output logic SDR_WE_N,
  output logic [1:0] SDR_BA,
  output logic [11:0] SDR_A,
  output logic [1:0] SDR_DQM,
  output logic [15:0] SDR_DQ_O,
  output logic SDR_DQ_OE_N,
  input wire logic [15:0] SDR_DQ_I
);
  typedef struct packed {
    sdt_state_t st;
    logic [1:0] ref_left;
    logic ref_pend;
    logic ready;
    logic cke;
    logic [3:0] cmd;
    logic [1:0] ba;
    logic [11:0] a;
    logic [1:0] dqm;
    logic [15:0] dq_o;
    logic dq_oe_n;
    logic wr;
    logic ap;
    logic [21:0] addr;
    logic ack;
    logic [CAS_LAT:0] rd_pipe;
    logic [15:0] rd_data;
    logic rd_valid;
  } sdt_ctl_t;

  sdt_ctl_t s_r;
  sdt_ctl_t s_nxt;
  sdt_tmr_if tmr ();

  logic [TW-1:0] rc_c;
  logic [TW-1:0] rp_c;
  logic [TW-1:0] rcd_c;
  logic [TW-1:0] rrd_c;
  logic [TW-1:0] dal_c;
  logic act_ok;

  sdt_timer u_tmr (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .t(tmr)
  );

  // Cycle counts of the selected grade, rounded up
  assign rc_c = GRADE_SLOW ? TW'(RC_SLOW_CYC) : TW'(RC_FAST_CYC);
  assign rp_c = GRADE_SLOW ? TW'(RP_SLOW_CYC) : TW'(RP_FAST_CYC);
  assign rcd_c = GRADE_SLOW ? TW'(RCD_SLOW_CYC) : TW'(RCD_FAST_CYC);
  assign rrd_c = GRADE_SLOW ? TW'(RRD_SLOW_CYC) : TW'(RRD_FAST_CYC);
  assign dal_c = TW'(WR_CLK) + rp_c;

  // Activation or refresh allowed
  assign act_ok = tmr.done[T_WAIT] && tmr.done[T_RP] && tmr.done[T_RC];

  always_comb
  begin
    s_nxt = s_r;
    tmr.load = '0;
    tmr.val = '0;
    s_nxt.cmd = CMD_NOP;
    s_nxt.ack = 1'b0;
    s_nxt.dq_oe_n = 1'b1;
    s_nxt.rd_pipe = {s_r.rd_pipe[CAS_LAT-1:0], 1'b0};
    s_nxt.rd_valid = s_r.rd_pipe[CAS_LAT];
    if (s_r.rd_pipe[CAS_LAT])
      s_nxt.rd_data = SDR_DQ_I;
    case (s_r.st)
      S_RESET:
      begin
        tmr.load[T_WAIT] = 1'b1;
        tmr.val[T_WAIT] = cyc(INIT_WAIT_CYC_P);
        s_nxt.st = S_INIT_WAIT;
      end
      S_INIT_WAIT:
      begin
        if (tmr.done[T_WAIT])
        begin
          s_nxt.cmd = CMD_PRE;
          s_nxt.a = 12'h400;
          tmr.load[T_RP] = 1'b1;
          tmr.val[T_RP] = cyc(int'(rp_c));
          s_nxt.st = S_INIT_REF;
        end
      end
      S_INIT_REF:
      begin
        if (act_ok)
        begin
          s_nxt.cmd = CMD_REF;
          tmr.load[T_RC] = 1'b1;
          tmr.val[T_RC] = cyc(int'(rc_c));
          s_nxt.ref_left = s_r.ref_left - 2'h1;
          if (s_r.ref_left == 2'h1)
            s_nxt.st = S_INIT_MRS;
        end
      end
      S_INIT_MRS:
      begin
        if (act_ok)
        begin
          s_nxt.cmd = CMD_MRS;
          s_nxt.ba = 2'h0;
          s_nxt.a = MODE_WORD;
          s_nxt.dqm = 2'h0;
          s_nxt.ready = 1'b1;
          tmr.load[T_WAIT] = 1'b1;
          tmr.val[T_WAIT] = cyc(MRD_CLK);
          s_nxt.st = S_IDLE;
        end
      end
      S_IDLE:
      begin
        if (s_r.ref_pend)
        begin
          if (act_ok)
          begin
            s_nxt.cmd = CMD_REF;
            s_nxt.ref_pend = 1'b0;
            tmr.load[T_RC] = 1'b1;
            tmr.val[T_RC] = cyc(int'(rc_c));
          end
        end
        else if (PWR_DOWN)
        begin
          if (tmr.done[T_WAIT])
          begin
            s_nxt.cke = 1'b0;
            s_nxt.st = S_PDN;
          end
        end
        else if (REQ && act_ok && tmr.done[T_RRD])
        begin
          s_nxt.cmd = CMD_ACT;
          s_nxt.ba = REQ_ADDR[21:20];
          s_nxt.a = REQ_ADDR[19:8];
          s_nxt.addr = REQ_ADDR;
          s_nxt.wr = REQ_WR;
          s_nxt.ap = REQ_AP & REQ_WR;
          s_nxt.dq_o = REQ_WDATA;
          tmr.load[T_RC] = 1'b1;
          tmr.val[T_RC] = cyc(int'(rc_c));
          tmr.load[T_RAS] = 1'b1;
          tmr.val[T_RAS] = cyc(RAS_MIN_CYC);
          tmr.load[T_RCD] = 1'b1;
          tmr.val[T_RCD] = cyc(int'(rcd_c));
          tmr.load[T_RRD] = 1'b1;
          tmr.val[T_RRD] = cyc(int'(rrd_c));
          s_nxt.st = S_RCD;
        end
      end
      S_RCD:
      begin
        if (tmr.done[T_RCD] && (!s_r.ap || tmr.done[T_RAS]))
        begin
          s_nxt.cmd = s_r.wr ? CMD_WR : CMD_RD;
          s_nxt.a = {1'b0, s_r.ap, 2'h0, s_r.addr[7:0]};
          s_nxt.ack = 1'b1;
          s_nxt.dq_oe_n = !s_r.wr;
          s_nxt.rd_pipe[0] = !s_r.wr;
          tmr.load[T_WAIT] = 1'b1;
          if (s_r.ap)
          begin
            tmr.val[T_WAIT] = cyc(int'(dal_c));
            tmr.load[T_RP] = 1'b1;
            tmr.val[T_RP] = cyc(int'(dal_c));
            s_nxt.st = S_IDLE;
          end
          else
          begin
            tmr.val[T_WAIT] = s_r.wr ? cyc(WR_CLK) : '0;
            s_nxt.st = S_PRE;
          end
        end
      end
      S_PRE:
      begin
        // Close the row as soon as allowed, which keeps it far below the maximum
        if (tmr.done[T_RAS] && tmr.done[T_WAIT])
        begin
          s_nxt.cmd = CMD_PRE;
          s_nxt.a = 12'h000;
          tmr.load[T_RP] = 1'b1;
          tmr.val[T_RP] = cyc(int'(rp_c));
          s_nxt.st = S_IDLE;
        end
      end
      S_PDN:
      begin
        if (!PWR_DOWN || s_r.ref_pend)
        begin
          s_nxt.cke = 1'b1;
          tmr.load[T_WAIT] = 1'b1;
          tmr.val[T_WAIT] = cyc(CKA_CYC);
          s_nxt.st = S_IDLE;
        end
      end
      default:
        s_nxt.st = S_RESET;
    endcase
    // Refresh tick; a tick in the cycle a refresh is issued is kept
    if (tmr.done[T_REFI])
    begin
      tmr.load[T_REFI] = 1'b1;
      tmr.val[T_REFI] = cyc(REFI_CYC);
      if (s_r.ready)
        s_nxt.ref_pend = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      s_r <= '0;
      s_r.st <= S_RESET;
      s_r.ref_left <= 2'(INIT_REFRESHES);
      s_r.cke <= 1'b1;
      s_r.cmd <= CMD_NOP;
      s_r.dqm <= 2'h3;
      s_r.dq_oe_n <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign ACK = s_r.ack;
  assign RD_DATA = s_r.rd_data;
  assign RD_VALID = s_r.rd_valid;
  assign READY = s_r.ready;
  assign SDR_CKE = s_r.cke;
  assign SDR_CS_N = s_r.cmd[3];
  assign SDR_RAS_N = s_r.cmd[2];
  assign SDR_CAS_N = s_r.cmd[1];
  assign SDR_WE_N = s_r.cmd[0];
  assign SDR_BA = s_r.ba;
  assign SDR_A = s_r.a;
  assign SDR_DQM = s_r.dqm;
  assign SDR_DQ_O = s_r.dq_o;
  assign SDR_DQ_OE_N = s_r.dq_oe_n;

  // Cycles since each event, for the checks below
  localparam int NH = 7;
  localparam int H_ACT = 0;
  localparam int H_PRE = 1;
  localparam int H_REF = 2;
  localparam int H_WAP = 3;
  localparam int H_MRS = 4;
  localparam int H_CKE = 5;
  localparam int H_RST = 6;
  localparam int REF_SLACK = 64;
  logic [NH-1:0][TW-1:0] h;
  logic [NH-1:0] ev;

  assign ev = {1'b0, !s_r.cke, s_r.cmd == CMD_MRS, s_r.cmd == CMD_WR && s_r.a[AP_BIT],
    s_r.cmd == CMD_REF, s_r.cmd == CMD_PRE, s_r.cmd == CMD_ACT};

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      h <= {TW'(0), {(NH-1)*TW{1'b1}}};
    else
      for (int i = 0; i < NH; i++)
        h[i] <= ev[i] ? TW'(1) : ((h[i] == '1) ? h[i] : h[i] + TW'(1));
  end

  a_act_rc_gap: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (s_r.cmd == CMD_ACT || s_r.cmd == CMD_REF) |-> h[H_ACT] >= rc_c && h[H_REF] >= rc_c)
    else $error("activate or refresh spacing below row cycle time");
  a_ras_min_hold: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (s_r.cmd == CMD_PRE && s_r.ready) |-> h[H_ACT] >= TW'(RAS_MIN_CYC))
    else $error("row precharged too soon after activate");
  a_ras_max_open: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (s_r.st == S_RCD || s_r.st == S_PRE) && s_r.cmd != CMD_ACT |-> h[H_ACT] < TW'(RAS_MAX_CYC_P))
    else $error("row left open too long");
  a_rp_before_act: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (s_r.cmd == CMD_ACT || s_r.cmd == CMD_REF) |-> h[H_PRE] >= rp_c)
    else $error("activate too soon after precharge");
  a_rcd_to_rw: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (s_r.cmd == CMD_RD || s_r.cmd == CMD_WR) |-> h[H_ACT] >= rcd_c && $past(s_r.st) == S_RCD)
    else $error("read or write too soon after activate");
  a_rrd_bank_gap: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    s_r.cmd == CMD_ACT |-> h[H_ACT] >= rrd_c)
    else $error("activates to banks too close");
  a_wr_to_pre: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (s_r.cmd == CMD_WR && !s_r.a[AP_BIT]) |=> s_r.cmd != CMD_PRE)
    else $error("precharge too soon after write data");
  a_dal_wait: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (s_r.cmd == CMD_ACT || s_r.cmd == CMD_REF) |-> h[H_WAP] >= dal_c)
    else $error("activate or refresh too soon after auto-precharge write");
  a_refresh_rate: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    s_r.ready |-> h[H_REF] <= TW'(REFI_CYC + REF_SLACK))
    else $error("refresh interval exceeded");
  a_cke_recover: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    $rose(s_r.cke) |-> (s_r.cmd == CMD_NOP) [*2])
    else $error("command too soon after clock enable raised");
  a_cke_count: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    s_r.cmd != CMD_NOP |-> s_r.cke && h[H_CKE] > TW'(CKA_CYC))
    else $error("command issued during clock enable recovery");
  a_power_up_wait: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (s_r.cmd != CMD_NOP || s_r.ready) |-> h[H_RST] >= TW'(INIT_WAIT_CYC_P))
    else $error("command before power-up wait ended");
  a_mrd_wait: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (s_r.cmd == CMD_ACT || s_r.cmd == CMD_REF) |-> h[H_MRS] >= TW'(MRD_CLK))
    else $error("activate or refresh too soon after mode load");
  a_grade_round: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    32'(rc_c) * CLK_PERIOD_PS >= (GRADE_SLOW ? RC_SLOW_NS : RC_FAST_NS) * 1000)
    else $error("row cycle count rounded below the time");
endmodule
`default_nettype wire

//--- verilog/sdt_timer.sv
// Bank of countdown timers; done is high while a timer stands at zero
`timescale 1ns/10ps
`default_nettype none
module sdt_timer import sdt_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  sdt_tmr_if.tmr t
);
  typedef struct packed {
    logic [NT-1:0][TW-1:0] cnt;
  } sdt_tmr_st_t;

  sdt_tmr_st_t s_r;
  sdt_tmr_st_t s_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++)
    begin : g_tmr
      assign t.done[gi] = (s_r.cnt[gi] == '0);
    end
  endgenerate

  // Load wins over the countdown; a timer rests at zero
  always_comb
  begin
    s_nxt = s_r;
    for (int i = 0; i < NT; i++)
    begin
      if (t.load[i])
        s_nxt.cnt[i] = t.val[i];
      else if (s_r.cnt[i] != '0)
        s_nxt.cnt[i] = s_r.cnt[i] - TW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule
`default_nettype wire
